// File: bench/scmc_clock_ctrl_properties.sv
// port assertions for the clock mode control block
`timescale 1ns/10ps
module scmc_clock_ctrl_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // processor side
  input wire logic stop_instruction,
  input wire logic ext_irq,
  input wire logic irq_accept,
  // clock and power outputs
  input wire logic main_osc_en,
  input wire logic sub_osc_en,
  input wire logic phi,
  input wire logic phi_rise,
  input wire logic reg_low_power,
  input wire logic [1:0] clk_state
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_stopped;
    clk_state == 2'b10 && phi && !main_osc_en && !sub_osc_en && reg_low_power;
  endsequence
  property p_reset_run;
    $rose(aresetn) |-> clk_state == 2'b00 && phi && main_osc_en && !sub_osc_en;
  endproperty
  a_reset_run: assert property (p_reset_run)
    else $error("state after reset wrong");
  property p_stop_enter;
    clk_state == 2'b00 && stop_instruction |=> s_stopped;
  endproperty
  a_stop_enter: assert property (p_stop_enter)
    else $error("stop not entered");
  property p_stop_hold;
    clk_state == 2'b10 |-> s_stopped;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stop outputs wrong");
  property p_stop_wake;
    clk_state == 2'b10 && ext_irq |=> clk_state == 2'b11;
  endproperty
  a_stop_wake: assert property (p_stop_wake)
    else $error("interrupt did not leave stop");
  property p_recover;
    clk_state == 2'b11 |-> phi && !reg_low_power;
  endproperty
  a_recover: assert property (p_recover)
    else $error("clock or regulator wrong in recovery");
  property p_wait_hold;
    clk_state == 2'b01 |-> phi && $stable(main_osc_en);
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("wait outputs wrong");
  property p_wait_wake;
    clk_state == 2'b01 && irq_accept |=> clk_state == 2'b00;
  endproperty
  a_wait_wake: assert property (p_wait_wake)
    else $error("interrupt did not leave wait");
  property p_phi_rise;
    phi_rise |-> !phi ##1 phi;
  endproperty
  a_phi_rise: assert property (p_phi_rise)
    else $error("rise marker not before clock rise");
endmodule : scmc_clock_ctrl_chk
bind scmc_clock_ctrl scmc_clock_ctrl_chk u_chk (.aclk(aclk),
  .aresetn(aresetn), .stop_instruction(stop_instruction),
  .ext_irq(ext_irq), .irq_accept(irq_accept),
  .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en), .phi(phi),
  .phi_rise(phi_rise), .reg_low_power(reg_low_power),
  .clk_state(clk_state));

// File: bench/scmc_clock_ctrl_test.sv
// self-checking bench for the clock mode control block
`timescale 1ns/10ps
module scmc_clock_ctrl_test;
  localparam logic [9:0] A_CPUM = {scmc_pkg::IDX_CPUM, 2'b00};
  localparam logic [9:0] A_MISC = {scmc_pkg::IDX_MISC, 2'b00};
  localparam logic [9:0] A_PRE = {scmc_pkg::IDX_PRE12, 2'b00};
  localparam logic [9:0] A_T1 = {scmc_pkg::IDX_T1, 2'b00};
  localparam logic [1:0] OK = scmc_pkg::RESP_OKAY;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, stop_instruction;
  logic wait_instruction, ext_irq, irq_accept, main_osc_in, sub_osc_in;
  logic main_osc_out, sub_osc_out, main_osc_en, sub_osc_en;
  logic sub_port_mode, phi, phi_rise, reg_low_power;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, clk_state;
  int fail_count = 0;
  int checked = 0;
  int n;
  scmc_clock_ctrl dut (.*);
  scmc_osc_model u_osc (.aclk(aclk), .main_en(main_osc_en),
    .sub_en(sub_osc_en), .main_in(main_osc_in), .sub_in(sub_osc_in));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string m);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, OK, "write response");
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] e,
    input logic [1:0] er, input string m);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h000000, e}, m);
    chk(s_axi_rresp, er, m);
  endtask : rd
  task automatic per_chk(input int exp, input string m);
    int k;
    k = 0;
    repeat (2)
    begin
      @(posedge aclk);
      while (phi_rise !== 1'b1)
        @(posedge aclk);
    end
    do
    begin
      @(posedge aclk);
      k++;
    end while (phi_rise !== 1'b1);
    chk(k, exp, m);
  endtask : per_chk
  task automatic enter_stop();
    stop_instruction <= 1'b1;
    @(posedge aclk);
    stop_instruction <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({clk_state, phi, reg_low_power, main_osc_en, sub_osc_en,
      main_osc_out, sub_osc_out}, 8'hB0, "stop outputs");
  endtask : enter_stop
  task automatic recover(input int lo, input int hi, input string m);
    ext_irq <= 1'b1;
    @(posedge aclk);
    ext_irq <= 1'b0;
    @(posedge aclk);
    n = 0;
    while (clk_state === 2'b11)
    begin
      chk(phi, 1'b1, "clock held");
      n++;
      @(posedge aclk);
    end
    chk(n >= lo && n <= hi, 1'b1, m);
  endtask : recover
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial
  begin
    #200000;
    fail_count++;
    $display("CHECK FAILED %0t timeout", $time);
    stop_test();
  end
  initial
  begin
    aresetn <= 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} <= 4'h0;
    {s_axi_rready, stop_instruction, wait_instruction} <= 3'h0;
    {ext_irq, irq_accept} <= 2'h0;
    {s_axi_awaddr, s_axi_araddr} <= 20'h00000;
    s_axi_wdata <= 32'h00000000;
    s_axi_wstrb <= 4'h1;
    {s_axi_awprot, s_axi_arprot} <= 6'h00;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({clk_state, sub_port_mode, main_osc_en}, 4'h3, "reset outputs");
    rd(A_CPUM, 8'h40, OK, "cpu mode reset");
    rd(A_MISC, 8'h00, OK, "misc reset");
    rd(A_PRE, 8'hFF, OK, "prescaler reset");
    rd(A_T1, 8'h01, OK, "timer 1 reset");
    rd(10'h3FC, 8'h00, scmc_pkg::RESP_SLVERR, "unmapped read");
    $display("test reset done");
    per_chk(32, "middle period");
    wr(A_CPUM, 8'h00);
    per_chk(8, "high period");
    wr(A_CPUM, 8'h10);
    chk(sub_port_mode, 1'b0, "sub pins oscillate");
    wr(A_CPUM, 8'h90);
    per_chk(28, "low period");
    wr(A_CPUM, 8'hB0);
    chk(main_osc_en, 1'b0, "main stopped");
    wr(A_CPUM, 8'h90);
    chk(main_osc_en, 1'b1, "main restarted");
    repeat (20) @(posedge aclk);
    wr(A_CPUM, 8'h10);
    per_chk(8, "high period again");
    $display("test speed done");
    wr(A_PRE, 8'h05);
    enter_stop();
    rd(A_PRE, 8'hFF, OK, "stop preset prescaler");
    rd(A_T1, 8'h01, OK, "stop preset timer 1");
    recover(2040, 2070, "preset delay");
    wr(A_MISC, 8'h03);
    wr(A_PRE, 8'h03);
    wr(A_T1, 8'h00);
    enter_stop();
    rd(A_PRE, 8'h03, OK, "kept prescaler");
    rd(A_T1, 8'h00, OK, "kept timer 1");
    recover(44, 62, "sub source delay");
    wr(A_MISC, 8'h01);
    wr(A_PRE, 8'hFF);
    wr(A_T1, 8'h09);
    enter_stop();
    recover(10230, 10260, "flash delay");
    $display("test stop done");
    wait_instruction <= 1'b1;
    @(posedge aclk);
    wait_instruction <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({clk_state, phi, main_osc_en}, 4'h7, "wait outputs");
    irq_accept <= 1'b1;
    @(posedge aclk);
    irq_accept <= 1'b0;
    @(posedge aclk);
    chk(clk_state, 2'b00, "wait wake");
    enter_stop();
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({clk_state, main_osc_en}, 3'h1, "reset leaves stop");
    $display("test wait and reset done");
    stop_test();
  end
endmodule : scmc_clock_ctrl_test

// File: bench/scmc_osc_model.sv
// resonator model driving the two oscillator input pins
`timescale 1ns/10ps
module scmc_osc_model (
  // clock
  input wire logic aclk,
  // oscillator enables
  input wire logic main_en,
  input wire logic sub_en,
  // oscillator levels
  output logic main_in,
  output logic sub_in
);
  int mc = 0;
  int sc = 0;
  initial main_in = 1'b0;
  initial sub_in = 1'b0;
  // main period 4, sub period 14
  always @(posedge aclk)
  begin
    mc <= main_en ? (mc + 1) % 2 : 0;
    sc <= sub_en ? (sc + 1) % 7 : 0;
    if (main_en && mc == 1)
      main_in <= !main_in;
    if (sub_en && sc == 6)
      sub_in <= !sub_in;
  end
endmodule : scmc_osc_model

// File: logic/scmc_clock_ctrl.sv
// system clock mode control with stop and wait states, AXI4-Lite registers
//
// Operation
// - middle speed: main input divided by 8
// - reset release selects middle speed
// - high speed: half the main input
// - low speed: half the sub input
// - power on: main only, sub pins ports
// - main stop bit halts main oscillator
// - stop: clock high, both oscillators halted
// - preset bit 0: load FF and 01
// - preset bit 1: keep software timer values
// - release: prescaler feeds timer 1, counting
// - interrupt restarts; clock waits for underflow
// - regulator low power during stop
// - wait: clock high, resumes on interrupt
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
module scmc_clock_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi write address
  input wire logic [scmc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi read address
  input wire logic [scmc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // processor side
  input wire logic stop_instruction,
  input wire logic wait_instruction,
  input wire logic ext_irq,
  input wire logic irq_accept,
  // oscillator pins
  input wire logic main_osc_in,
  input wire logic sub_osc_in,
  output logic main_osc_out,
  output logic sub_osc_out,
  output logic main_osc_en,
  output logic sub_osc_en,
  output logic sub_port_mode,
  // system clock and power
  output logic phi,
  output logic phi_rise,
  output logic reg_low_power,
  output logic [1:0] clk_state
);

  scmc_pkg::scmc_state_t state_q;
  logic [7:0] cpum_q;
  logic [7:0] misc_q;
  logic cs_sub_q;
  logic main_in_q;
  logic sub_in_q;
  logic main_out_q;
  logic sub_out_q;
  logic lowpwr_q;
  logic main_on;
  logic sub_on;
  logic main_tick;
  logic sub_tick;
  logic src_tick;
  logic stop_entry;
  logic preset;
  logic t1_uf;
  logic [7:0] pre_cnt;
  logic [7:0] t1_cnt;

  // axi state
  logic aw_full_q;
  logic w_full_q;
  logic [scmc_pkg::ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_go;
  logic wr_en;
  scmc_pkg::scmc_sel_t wr_sel;
  scmc_pkg::scmc_sel_t rd_sel;
  logic [7:0] rd_val;
  logic load_pre;
  logic load_t1;
  logic [7:0] pre_val;
  logic [7:0] t1_val;

  // oscillator control and tick detection
  always_comb
  begin
    main_on = !cpum_q[scmc_pkg::CPUM_MAIN_STOP] &&
      state_q != scmc_pkg::ST_STOP;
    sub_on = cpum_q[scmc_pkg::CPUM_SUB_EN] &&
      state_q != scmc_pkg::ST_STOP;
    main_tick = main_on && main_osc_in && !main_in_q;
    sub_tick = sub_on && sub_osc_in && !sub_in_q;
    src_tick = cs_sub_q ? sub_tick : main_tick;
    stop_entry = state_q == scmc_pkg::ST_RUN && stop_instruction;
    preset = stop_entry && !misc_q[scmc_pkg::MISC_STAB_KEEP];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      main_in_q <= 1'b0;
      sub_in_q <= 1'b0;
      main_out_q <= 1'b0;
      sub_out_q <= 1'b0;
    end
    else
    begin
      main_in_q <= main_osc_in;
      sub_in_q <= sub_osc_in;
      main_out_q <= main_on && !main_osc_in;
      sub_out_q <= sub_on && !sub_osc_in;
    end
  end

  // low-power state machine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= scmc_pkg::ST_RUN;
    end
    else
    begin
      case (state_q)
        scmc_pkg::ST_RUN:
        begin
          if (stop_instruction)
          begin
            state_q <= scmc_pkg::ST_STOP;
          end
          else if (wait_instruction)
          begin
            state_q <= scmc_pkg::ST_WAIT;
          end
        end
        scmc_pkg::ST_WAIT:
        begin
          if (irq_accept)
          begin
            state_q <= scmc_pkg::ST_RUN;
          end
        end
        scmc_pkg::ST_STOP:
        begin
          if (ext_irq)
          begin
            state_q <= scmc_pkg::ST_RECOVER;
          end
        end
        scmc_pkg::ST_RECOVER:
        begin
          if (t1_uf)
          begin
            state_q <= scmc_pkg::ST_RUN;
          end
        end
        default: state_q <= scmc_pkg::ST_RUN;
      endcase
    end
  end

  // count source latched at stop entry
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cs_sub_q <= 1'b0;
    end
    else if (stop_entry)
    begin
      cs_sub_q <= misc_q[scmc_pkg::MISC_CS_SUB];
    end
  end

  // regulator power mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lowpwr_q <= 1'b0;
    end
    else if (stop_entry)
    begin
      lowpwr_q <= scmc_pkg::LV_VARIANT;
    end
    else if (state_q == scmc_pkg::ST_STOP && ext_irq)
    begin
      lowpwr_q <= 1'b0;
    end
  end

  // timer loads from stop preset or software
  always_comb
  begin
    wr_en = wr_go && w_strb_q;
    load_pre = preset || (wr_en && wr_sel == scmc_pkg::SEL_PRE);
    load_t1 = preset || (wr_en && wr_sel == scmc_pkg::SEL_T1);
    pre_val = preset ? scmc_pkg::PRE12_STOP : w_data_q;
    t1_val = preset ? scmc_pkg::T1_STOP : w_data_q;
  end

  scmc_stab_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(state_q == scmc_pkg::ST_RECOVER),
    .src_tick(src_tick),
    .load_pre(load_pre),
    .load_t1(load_t1),
    .pre_val(pre_val),
    .t1_val(t1_val),
    .pre_cnt(pre_cnt),
    .t1_cnt(t1_cnt),
    .underflow(t1_uf)
  );

  scmc_phi_gen u_phi (
    .aclk(aclk),
    .aresetn(aresetn),
    .main_tick(main_tick),
    .sub_tick(sub_tick),
    .speed(scmc_pkg::scmc_speed_t'(cpum_q[scmc_pkg::CPUM_SPD_LSB +: 2])),
    .hold_high(state_q != scmc_pkg::ST_RUN || stop_instruction ||
      wait_instruction),
    .phi(phi),
    .phi_rise(phi_rise)
  );

  // write channel capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (wr_go)
    begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_q <= 1'b0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata[7:0];
      w_strb_q <= s_axi_wstrb[0];
    end
    else if (wr_go)
    begin
      w_full_q <= 1'b0;
    end
  end

  always_comb
  begin
    wr_go = aw_full_q && w_full_q && !bvalid_q;
    wr_sel = scmc_pkg::reg_decode(aw_addr_q);
    rd_sel = scmc_pkg::reg_decode(s_axi_araddr);
    case (rd_sel)
      scmc_pkg::SEL_CPUM: rd_val = cpum_q;
      scmc_pkg::SEL_MISC: rd_val = {4'h0, state_q, misc_q[1:0]};
      scmc_pkg::SEL_PRE: rd_val = pre_cnt;
      scmc_pkg::SEL_T1: rd_val = t1_cnt;
      default: rd_val = 8'h00;
    endcase
  end

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= scmc_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_sel == scmc_pkg::SEL_NONE) ?
        scmc_pkg::RESP_SLVERR : scmc_pkg::RESP_OKAY;
    end
    else if (s_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  // control registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cpum_q <= scmc_pkg::CPUM_RST;
      misc_q <= scmc_pkg::MISC_RST;
    end
    else if (wr_en && wr_sel == scmc_pkg::SEL_CPUM)
    begin
      cpum_q <= w_data_q & scmc_pkg::CPUM_WMASK;
    end
    else if (wr_en && wr_sel == scmc_pkg::SEL_MISC)
    begin
      misc_q <= w_data_q & scmc_pkg::MISC_WMASK;
    end
  end

  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= scmc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_val};
      rresp_q <= (rd_sel == scmc_pkg::SEL_NONE) ?
        scmc_pkg::RESP_SLVERR : scmc_pkg::RESP_OKAY;
    end
    else if (s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready = !w_full_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign main_osc_out = main_out_q;
  assign sub_osc_out = sub_out_q;
  assign main_osc_en = main_on;
  assign sub_osc_en = sub_on;
  // sub pins are ports when sub off
  assign sub_port_mode = !cpum_q[scmc_pkg::CPUM_SUB_EN];
  assign reg_low_power = lowpwr_q;
  assign clk_state = state_q;

endmodule : scmc_clock_ctrl

// File: logic/scmc_phi_gen.sv
// system clock divider with glitch-free source and ratio switching
`timescale 1ns/10ps
module scmc_phi_gen (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // source ticks
  input wire logic main_tick,
  input wire logic sub_tick,
  // control
  input wire scmc_pkg::scmc_speed_t speed,
  input wire logic hold_high,
  // system clock
  output logic phi,
  output logic phi_rise
);

  scmc_pkg::scmc_speed_t act_q;
  logic [1:0] cnt_q;
  logic phi_q;
  logic tick;
  logic [1:0] half;
  logic flip;

  always_comb
  begin
    tick = (act_q == scmc_pkg::SPD_LOW) ? sub_tick : main_tick;
    half = (act_q == scmc_pkg::SPD_HIGH || act_q == scmc_pkg::SPD_LOW) ?
      scmc_pkg::FAST_HALF : scmc_pkg::MID_HALF;
    flip = tick && (cnt_q == half) && !hold_high;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      act_q <= scmc_pkg::SPD_MID;
      cnt_q <= 2'h0;
      phi_q <= 1'b1;
    end
    else if (hold_high)
    begin
      phi_q <= 1'b1;
      cnt_q <= 2'h0;
    end
    else if (tick)
    begin
      if (flip)
      begin
        cnt_q <= 2'h0;
        phi_q <= ~phi_q;
        if (!phi_q)
        begin
          act_q <= speed;
        end
      end
      else
      begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end

  assign phi = phi_q;
  assign phi_rise = flip && !phi_q;

endmodule : scmc_phi_gen

// File: logic/scmc_pkg.sv
// shared constants and types for the system clock mode control block
package scmc_pkg;

  // register indices; byte address is four times the index
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_MISC = 8'h10;
  localparam logic [7:0] IDX_PRE12 = 8'h20;
  localparam logic [7:0] IDX_T1 = 8'h21;
  localparam logic [7:0] IDX_CPUM = 8'h3B;

  // processor mode register fields
  localparam int CPUM_SPD_LSB = 6;
  localparam int CPUM_MAIN_STOP = 5;
  localparam int CPUM_SUB_EN = 4;
  localparam logic [7:0] CPUM_RST = 8'h40;
  localparam logic [7:0] CPUM_WMASK = 8'hF0;

  // misc register fields
  localparam int MISC_STAB_KEEP = 0;
  localparam int MISC_CS_SUB = 1;
  localparam int MISC_STATE_LSB = 2;
  localparam logic [7:0] MISC_RST = 8'h00;
  localparam logic [7:0] MISC_WMASK = 8'h03;

  // stabilisation timer reset and stop preset values
  localparam logic [7:0] PRE12_RST = 8'hFF;
  localparam logic [7:0] T1_RST = 8'h01;
  localparam logic [7:0] PRE12_STOP = 8'hFF;
  localparam logic [7:0] T1_STOP = 8'h01;

  // division: middle speed divides the main input by 8, others by 2
  localparam int MID_DIV = 8;
  localparam int FAST_DIV = 2;
  localparam logic [1:0] MID_HALF = 2'(MID_DIV / 2 - 1);
  localparam logic [1:0] FAST_HALF = 2'(FAST_DIV / 2 - 1);

  // low-voltage flash variant puts the regulator in low power in stop
  localparam logic LV_VARIANT = 1'b1;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SPD_HIGH = 2'b00,
    SPD_MID = 2'b01,
    SPD_LOW = 2'b10
  } scmc_speed_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WAIT = 2'b01,
    ST_STOP = 2'b10,
    ST_RECOVER = 2'b11
  } scmc_state_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_CPUM = 3'b001,
    SEL_MISC = 3'b010,
    SEL_PRE = 3'b011,
    SEL_T1 = 3'b100
  } scmc_sel_t;

  // decode a byte address into a register selection
  function automatic scmc_sel_t reg_decode(input logic [ADDR_W-1:0] addr);
    scmc_sel_t sel;
    sel = SEL_NONE;
    if (addr[1:0] == 2'h0)
    begin
      case (addr[ADDR_W-1:2])
        IDX_CPUM: sel = SEL_CPUM;
        IDX_MISC: sel = SEL_MISC;
        IDX_PRE12: sel = SEL_PRE;
        IDX_T1: sel = SEL_T1;
        default: sel = SEL_NONE;
      endcase
    end
    return sel;
  endfunction : reg_decode

endpackage : scmc_pkg

// File: logic/scmc_stab_timer.sv
// prescaler 12 chained into timer 1 for the stop release delay
`timescale 1ns/10ps
module scmc_stab_timer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // counting
  input wire logic run,
  input wire logic src_tick,
  // loads
  input wire logic load_pre,
  input wire logic load_t1,
  input wire logic [7:0] pre_val,
  input wire logic [7:0] t1_val,
  // state
  output logic [7:0] pre_cnt,
  output logic [7:0] t1_cnt,
  output logic underflow
);

  logic [7:0] pre_lat_q;
  logic [7:0] pre_q;
  logic [7:0] t1_lat_q;
  logic [7:0] t1_q;
  logic uf_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_lat_q <= scmc_pkg::PRE12_RST;
      pre_q <= scmc_pkg::PRE12_RST;
    end
    else if (load_pre)
    begin
      pre_lat_q <= pre_val;
      pre_q <= pre_val;
    end
    else if (run && src_tick)
    begin
      pre_q <= (pre_q == 8'h00) ? pre_lat_q : pre_q - 8'h01;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      t1_lat_q <= scmc_pkg::T1_RST;
      t1_q <= scmc_pkg::T1_RST;
      uf_q <= 1'b0;
    end
    else
    begin
      uf_q <= 1'b0;
      if (load_t1)
      begin
        t1_lat_q <= t1_val;
        t1_q <= t1_val;
      end
      else if (run && src_tick && pre_q == 8'h00)
      begin
        if (t1_q == 8'h00)
        begin
          t1_q <= t1_lat_q;
          uf_q <= 1'b1;
        end
        else
        begin
          t1_q <= t1_q - 8'h01;
        end
      end
    end
  end

  assign pre_cnt = pre_q;
  assign t1_cnt = t1_q;
  assign underflow = uf_q;

endmodule : scmc_stab_timer
